// ---- src/analog_out_pkg.sv ----
/*
  Shared constants for the analog output board logic: serial bit bus
  address layout, word and channel sizes, and timing figures.
  Assumes a single 125 MHz clock shared by every design file.
*/
package analog_out_pkg;

  // Clock rate
  localparam int CLK_MHZ = 125;             // System clock in MHz
  localparam int CLK_KHZ = CLK_MHZ * 1000;  // Same rate in kHz

  // Converter word and channel layout
  localparam int WORD_W  = 12;              // Converter word width
  localparam int NUM_CH  = 5;               // X, Y, Z, fourth axis, spindle
  localparam int CH_W    = 3;               // Channel field width
  localparam int BIT_W   = 4;               // Bit index field width
  localparam int ADDR_W  = CH_W + BIT_W;    // Bit bus address width
  localparam int FIFO_DEPTH = 16;           // Words buffered before converter

  // Bit bus address fields
  localparam int ADDR_BIT_LSB = 0;          // Bit index starts here
  localparam int ADDR_CH_LSB  = BIT_W;      // Channel field starts here
  localparam logic [BIT_W-1:0] LAST_BIT   = 4'hb;  // Final bit closes a word
  localparam logic [CH_W-1:0]  STATUS_CH  = 3'h7;  // Readback channel code

  // Readback bit indexes within the status channel
  localparam logic [BIT_W-1:0] ST_OVERRIDE = 4'h0; // Override comparison
  localparam logic [BIT_W-1:0] ST_FEED     = 4'h1; // Feed comparison
  localparam logic [BIT_W-1:0] ST_BATTERY  = 4'h2; // Battery low
  localparam logic [BIT_W-1:0] ST_TEMP     = 4'h3; // Over temperature
  localparam logic [BIT_W-1:0] ST_ESTOP    = 4'h4; // Emergency stop latched

  // Watchdog intervals
  localparam int WD_FAST_MS  = 5;           // Axis control processor
  localparam int WD_SLOW_MS  = 20;          // Main processor
  localparam int WD_FAST_CYC = WD_FAST_MS * CLK_KHZ;
  localparam int WD_SLOW_CYC = WD_SLOW_MS * CLK_KHZ;
  localparam int WD_CNT_W    = 22;          // Holds the 20 ms count

  // Converter settling and sample-and-hold pulse, least times rounded up
  localparam int SETTLE_NS  = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_NS    = 400;
  localparam int HOLD_CYC   = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int SEQ_CNT_W  = 9;            // Covers both counts

endpackage

// ---- src/word_fifo.sv ----
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes both sides share one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];     // Storage
  logic [PW-1:0]    wr_r;              // Write index
  logic [PW-1:0]    rd_r;              // Read index
  logic [PW:0]      cnt_r;             // Occupancy
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // Index and count upkeep
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// ---- src/analog_board_output_and_watchdog.sv ----
/*
  Digital part of the analog output board: serial bit bus receiver that
  assembles converter words, a sequencer that drives one output converter
  and five sample-and-hold channels, status readback, and two watchdogs.
  Assumes all pin inputs are asynchronous to clock and are held stable
  for at least four clocks around each strobe edge.
*/
// Behaviour
// - Serial bits assembled into 12-bit words.
// - Five channels share converter, each own hold.
// - Potentiometer comparisons returned on serial input.
// - Battery and temperature flags readable serially.
// - Missed retrigger raises emergency stop.
`timescale 1ns/10ps
module analog_board_output_and_watchdog
  import analog_out_pkg::*;
#(
  parameter int WD_FAST_LIMIT = WD_FAST_CYC,
  parameter int WD_SLOW_LIMIT = WD_SLOW_CYC
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              serial_bit_out_line,
  input  wire logic              bit_strobe,
  input  wire logic [ADDR_W-1:0] bit_addr,
  output logic                   serial_bit_in_line,
  output logic                   bus_ready,
  input  wire logic              override_cmp,
  input  wire logic              feed_cmp,
  input  wire logic              battery_low,
  input  wire logic              over_temp,
  input  wire logic              axis_ctrl_retrigger,
  input  wire logic              main_retrigger,
  output logic      [WORD_W-1:0] converter_data,
  output logic      [NUM_CH-1:0] hold_strobe,
  output logic                   emergency_stop
);
  localparam int SW = ADDR_W + 8;      // Synchronised input vector width
  localparam int FW = CH_W + WORD_W;   // FIFO entry width

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_HOLD} seq_t;

  logic [SW-1:0]     sync1_r;          // First stage, read by second only
  logic [SW-1:0]     sync2_r;          // Safe copies of pin inputs
  logic              strobe_d_r;       // Strobe delayed for edge detect
  logic [1:0]        retrig_d_r;       // Retriggers delayed for edges
  logic              s_data;
  logic              s_strobe;
  logic [ADDR_W-1:0] s_addr;
  logic              s_override, s_feed, s_batt, s_temp;
  logic [1:0]        s_retrig;
  logic [CH_W-1:0]   a_ch;             // Channel field of address
  logic [BIT_W-1:0]  a_bit;            // Bit index field of address
  logic              strobe_rise;
  logic [WORD_W-1:0] shift_r;          // Word under assembly
  logic [WORD_W-1:0] shift_nxt;
  logic              push_valid_r;     // Finished word waiting for FIFO
  logic [FW-1:0]     push_data_r;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [FW-1:0]     fifo_out_data;
  seq_t              seq_r;            // Converter sequencer state
  logic [SEQ_CNT_W-1:0] seq_cnt_r;     // Settle / hold countdown
  logic [CH_W-1:0]   cur_ch_r;         // Channel being converted
  logic              cmp_override_r;   // Latest override comparison
  logic              cmp_feed_r;       // Latest feed comparison
  logic [WD_CNT_W-1:0] wd_cnt_r [2];   // Watchdog counters
  logic [1:0]        wd_expired;
  logic              in_line_nxt;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge clock) begin
    sync1_r <= {main_retrigger, axis_ctrl_retrigger, over_temp, battery_low,
                feed_cmp, override_cmp, bit_strobe, serial_bit_out_line,
                bit_addr};
    sync2_r <= sync1_r;
  end

  assign s_addr     = sync2_r[ADDR_W-1:0];
  assign s_data     = sync2_r[ADDR_W];
  assign s_strobe   = sync2_r[ADDR_W+1];
  assign s_override = sync2_r[ADDR_W+2];
  assign s_feed     = sync2_r[ADDR_W+3];
  assign s_batt     = sync2_r[ADDR_W+4];
  assign s_temp     = sync2_r[ADDR_W+5];
  assign s_retrig   = sync2_r[ADDR_W+7:ADDR_W+6];
  assign a_ch       = s_addr[ADDR_CH_LSB +: CH_W];
  assign a_bit      = s_addr[ADDR_BIT_LSB +: BIT_W];
  assign strobe_rise = s_strobe && !strobe_d_r;

  // Edge detect history, taken from the second stage only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strobe_d_r <= 1'b0;
      retrig_d_r <= '0;
    end else begin
      strobe_d_r <= s_strobe;
      retrig_d_r <= s_retrig;
    end
  end

  // Next word value with the strobed bit placed at its index
  always_comb begin
    shift_nxt = shift_r;
    if (a_bit < BIT_W'(WORD_W)) begin
      shift_nxt[a_bit] = s_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_r      <= '0;
      push_valid_r <= 1'b0;
      push_data_r  <= '0;
    end else begin
      if (push_valid_r && fifo_in_ready) begin
        push_valid_r <= 1'b0;
      end
      // Writes during a pending push are dropped; the host watches bus_ready
      if (strobe_rise && a_ch < CH_W'(NUM_CH) && !push_valid_r) begin
        shift_r <= shift_nxt;
        if (a_bit == LAST_BIT) begin
          push_valid_r <= 1'b1;
          push_data_r  <= {a_ch, shift_nxt};
        end
      end
    end
  end

  // Ready seen by the processor, low while a word waits or FIFO is full
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_ready <= 1'b0;
    end else begin
      bus_ready <= !push_valid_r && fifo_in_ready;
    end
  end

  word_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push_valid_r),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Sequencer only drains while idle, so a slow converter fills the FIFO
  assign fifo_out_ready = (seq_r == SEQ_IDLE);

  // one converter, routed to per-channel hold
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seq_r          <= SEQ_IDLE;
      seq_cnt_r      <= '0;
      cur_ch_r       <= '0;
      converter_data <= '0;
      hold_strobe    <= '0;
    end else begin
      case (seq_r)
        SEQ_IDLE: begin
          hold_strobe <= '0;
          if (fifo_out_valid) begin
            converter_data <= fifo_out_data[WORD_W-1:0];
            cur_ch_r       <= fifo_out_data[FW-1:WORD_W];
            seq_cnt_r      <= SEQ_CNT_W'(SETTLE_CYC - 1);
            seq_r          <= SEQ_SETTLE;
          end
        end
        SEQ_SETTLE: begin
          if (seq_cnt_r == '0) begin
            // Only the converted channel's hold samples
            hold_strobe <= NUM_CH'(1) << cur_ch_r;
            seq_cnt_r   <= SEQ_CNT_W'(HOLD_CYC - 1);
            seq_r       <= SEQ_HOLD;
          end else begin
            seq_cnt_r <= seq_cnt_r - 1'b1;
          end
        end
        SEQ_HOLD: begin
          if (seq_cnt_r == '0) begin
            hold_strobe <= '0;
            seq_r       <= SEQ_IDLE;
          end else begin
            seq_cnt_r <= seq_cnt_r - 1'b1;
          end
        end
        default: begin
          hold_strobe <= '0;
          seq_r       <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmp_override_r <= 1'b0;
      cmp_feed_r     <= 1'b0;
    end else if (seq_r == SEQ_SETTLE && seq_cnt_r == '0) begin
      cmp_override_r <= s_override;
      cmp_feed_r     <= s_feed;
    end
  end

  // Readback select from the status channel
  always_comb begin
    in_line_nxt = 1'b0;
    if (a_ch == STATUS_CH) begin
      case (a_bit)
        ST_OVERRIDE: in_line_nxt = cmp_override_r;
        ST_FEED:     in_line_nxt = cmp_feed_r;
        ST_BATTERY:  in_line_nxt = s_batt;
        ST_TEMP:     in_line_nxt = s_temp;
        ST_ESTOP:    in_line_nxt = emergency_stop;
        default:     in_line_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serial_bit_in_line <= 1'b0;
    end else begin
      serial_bit_in_line <= in_line_nxt;
    end
  end

  // each processor retriggers its own counter
  generate
    for (genvar i = 0; i < 2; i++) begin : g_wd
      localparam int LIMIT = (i == 0) ? WD_FAST_LIMIT : WD_SLOW_LIMIT;
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          wd_cnt_r[i] <= '0;
        end else if (s_retrig[i] && !retrig_d_r[i]) begin
          wd_cnt_r[i] <= '0;
        end else if (wd_cnt_r[i] != WD_CNT_W'(LIMIT)) begin
          wd_cnt_r[i] <= wd_cnt_r[i] + 1'b1;
        end
      end
      assign wd_expired[i] = (wd_cnt_r[i] == WD_CNT_W'(LIMIT));
    end
  endgenerate

  // timeout latches emergency stop until reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      emergency_stop <= 1'b0;
    end else if (|wd_expired) begin
      emergency_stop <= 1'b1;
    end
  end

  // Assertions
  assembled_word_a: assert property (@(posedge clock) disable iff (!rst_n)
    strobe_rise && a_ch < CH_W'(NUM_CH) && !push_valid_r && a_bit == LAST_BIT
    |=> push_valid_r && push_data_r == {$past(a_ch), $past(shift_nxt)})
    else $error("finished word not queued");
  hold_onehot_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(|hold_strobe) |-> $onehot(hold_strobe)
      && hold_strobe == NUM_CH'(1) << cur_ch_r && seq_r == SEQ_HOLD)
    else $error("hold strobe on wrong channel");
  cmp_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
    a_ch == STATUS_CH && a_bit == ST_FEED |=> serial_bit_in_line == $past(cmp_feed_r))
    else $error("feed comparison not returned");
  temp_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
    a_ch == STATUS_CH && a_bit == ST_TEMP |=> serial_bit_in_line == $past(s_temp))
    else $error("temperature flag not returned");
  estop_timeout_a: assert property (@(posedge clock) disable iff (!rst_n)
    |wd_expired |=> emergency_stop)
    else $error("watchdog timeout without emergency stop");
  estop_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(emergency_stop) |-> $past(|wd_expired))
    else $error("emergency stop without timeout");
  channel_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    seq_r == SEQ_IDLE && fifo_out_valid
    |=> cur_ch_r == $past(fifo_out_data[FW-1:WORD_W]))
    else $error("channel not taken from queued address");

endmodule

// ---- sim/proc_model.sv ----
/*
  Behavioural model of the two processors on the far side of the board:
  serial bit bus writes, status readback and both watchdog retriggers.
  Assumes tasks are entered just after a rising clock edge.
*/
`timescale 1ns/10ps
module proc_model
  import analog_out_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              serial_bit_in_line,
  output logic                   serial_bit_out_line,
  output logic                   bit_strobe,
  output logic      [ADDR_W-1:0] bit_addr,
  output logic                   axis_ctrl_retrigger,
  output logic                   main_retrigger
);
  int fast_gap = 100;  // Cycles between fast retriggers, huge stops them
  int slow_gap = 250;  // Cycles between slow retriggers
  int fast_cnt = 0;    // Cycles since last fast pulse began
  int slow_cnt = 0;    // Cycles since last slow pulse began

  // Idle bus at time zero
  initial begin
    serial_bit_out_line = 1'b0;
    bit_strobe          = 1'b0;
    bit_addr            = '0;
    axis_ctrl_retrigger = 1'b0;
    main_retrigger      = 1'b0;
  end

  // periodic retrigger pulses
  // Four-cycle pulses so the board's synchronisers always see them
  always @(posedge clock) begin
    fast_cnt            <= (fast_cnt >= fast_gap - 1) ? 0 : fast_cnt + 1;
    slow_cnt            <= (slow_cnt >= slow_gap - 1) ? 0 : slow_cnt + 1;
    axis_ctrl_retrigger <= (fast_cnt < 4);
    main_retrigger      <= (slow_cnt < 4);
  end

  // one word, bit by bit, channel in address
  task automatic send_word(input logic [CH_W-1:0] ch, input logic [WORD_W-1:0] val);
    for (int i = 0; i < WORD_W; i++) begin
      bit_addr            <= {ch, i[BIT_W-1:0]};
      serial_bit_out_line <= val[i];
      repeat (4) @(posedge clock);
      bit_strobe <= 1'b1;
      repeat (4) @(posedge clock);
      bit_strobe <= 1'b0;
      repeat (2) @(posedge clock);
      // Stale data is shown inverted once the hold time is over
      serial_bit_out_line <= ~val[i];
      repeat (2) @(posedge clock);
    end
  endtask

  // Address one status bit and sample the answer mid-cycle
  task automatic read_bit(input logic [BIT_W-1:0] idx, output logic val);
    bit_addr <= {STATUS_CH, idx};
    repeat (6) @(posedge clock);
    @(negedge clock);
    val = serial_bit_in_line;
    @(posedge clock);
  endtask
endmodule

// ---- sim/analog_board_output_and_watchdog_tb.sv ----
/*
  Self-checking bench for the analog output board logic.
  Assumes the processor model in proc_model.sv and shortened watchdogs.
*/
`timescale 1ns/10ps
module analog_board_output_and_watchdog_tb;
  import analog_out_pkg::*;
  localparam int FAST_LIM = 200;  // Shortened fast watchdog
  localparam int SLOW_LIM = 500;  // Shortened slow watchdog

  logic              clock        = 1'b0;
  logic              rst_n        = 1'b0;
  logic              override_cmp = 1'b0;
  logic              feed_cmp     = 1'b0;
  logic              battery_low  = 1'b0;
  logic              over_temp    = 1'b0;
  logic              serial_bit_out_line;
  logic              bit_strobe;
  logic [ADDR_W-1:0] bit_addr;
  logic              serial_bit_in_line;
  logic              bus_ready;
  logic              axis_ctrl_retrigger;
  logic              main_retrigger;
  logic [WORD_W-1:0] converter_data;
  logic [NUM_CH-1:0] hold_strobe;
  logic              emergency_stop;
  int                n_errors    = 0;  // Mismatches seen
  int                comparisons = 0;  // Checks made
  int                cycles      = 0;  // Hang guard

  analog_board_output_and_watchdog #(.WD_FAST_LIMIT(FAST_LIM), .WD_SLOW_LIMIT(SLOW_LIM)) i_dut (
    .clock(clock), .rst_n(rst_n), .serial_bit_out_line(serial_bit_out_line),
    .bit_strobe(bit_strobe), .bit_addr(bit_addr), .serial_bit_in_line(serial_bit_in_line),
    .bus_ready(bus_ready), .override_cmp(override_cmp), .feed_cmp(feed_cmp),
    .battery_low(battery_low), .over_temp(over_temp),
    .axis_ctrl_retrigger(axis_ctrl_retrigger), .main_retrigger(main_retrigger),
    .converter_data(converter_data), .hold_strobe(hold_strobe),
    .emergency_stop(emergency_stop));

  proc_model i_proc (
    .clock(clock), .serial_bit_in_line(serial_bit_in_line),
    .serial_bit_out_line(serial_bit_out_line), .bit_strobe(bit_strobe),
    .bit_addr(bit_addr), .axis_ctrl_retrigger(axis_ctrl_retrigger),
    .main_retrigger(main_retrigger));

  // Free-running clock
  initial begin
    forever #4 clock = ~clock;
  end

  // Hang guard, far above the few thousand cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic summarize;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reset for 8 cycles, outputs quiet, then ready
  task automatic do_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (7) @(posedge clock);
    @(negedge clock);
    i_proc.fast_gap = 100;
    i_proc.slow_gap = 250;
    chk(16'({bus_ready, emergency_stop, hold_strobe}), 16'h0);
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(16'({bus_ready, emergency_stop}), 16'h2);
    @(posedge clock);
  endtask

  // One word through converter and its hold channel
  task automatic convert(input logic [CH_W-1:0] ch, input logic [WORD_W-1:0] val);
    int w;
    w = 0;
    i_proc.send_word(ch, val);
    while (hold_strobe === '0 && w < 600) begin
      @(negedge clock);
      w++;
    end
    chk(16'(hold_strobe), 16'h1 << ch);
    chk(16'(converter_data), 16'(val));
    w = 0;
    while (hold_strobe !== '0 && w < 100) begin
      @(negedge clock);
      w++;
    end
    chk(16'(w), 16'(HOLD_CYC));
    @(posedge clock);
  endtask

  // Every channel, then a refused channel code
  task automatic test_channels;
    logic [WORD_W-1:0] vals [NUM_CH];
    int                hits;
    vals = '{12'hfff, 12'h000, 12'ha5c, 12'h3c1, 12'h801};
    hits = 0;
    for (int c = 0; c < NUM_CH; c++) begin
      convert(c[CH_W-1:0], vals[c]);
    end
    i_proc.send_word(3'h5, 12'h123);
    repeat (400) begin
      @(negedge clock);
      hits += (hold_strobe !== '0);
    end
    chk(16'(hits), 16'h0);
    chk(16'(converter_data), 16'h801);
    chk(16'(emergency_stop), 16'h0);
    @(posedge clock);
  endtask

  // Comparison and supervision bits in both polarities
  task automatic test_status;
    logic b;
    for (int k = 0; k < 2; k++) begin
      override_cmp <= k[0];
      feed_cmp     <= ~k[0];
      battery_low  <= ~k[0];
      over_temp    <= k[0];
      convert(3'h2, 12'h5a5);
      i_proc.read_bit(ST_OVERRIDE, b);
      chk(16'(b), 16'(k[0]));
      i_proc.read_bit(ST_FEED, b);
      chk(16'(b), 16'(!k[0]));
      i_proc.read_bit(ST_BATTERY, b);
      chk(16'(b), 16'(!k[0]));
      i_proc.read_bit(ST_TEMP, b);
      chk(16'(b), 16'(k[0]));
    end
  endtask

  // Stop one retrigger and time the emergency stop
  task automatic test_wd(input logic fast);
    int   n;
    int   w;
    int   lim;
    logic b;
    lim = fast ? FAST_LIM : SLOW_LIM;
    w   = 0;
    // Start from a fresh retrigger, not from the reset release
    @(negedge clock);
    while ((fast ? i_proc.fast_cnt : i_proc.slow_cnt) != 8 && w < 600) begin
      @(negedge clock);
      w++;
    end
    if (fast) begin
      i_proc.fast_gap = 1000000;
    end else begin
      i_proc.slow_gap = 1000000;
    end
    @(negedge clock);
    n = fast ? i_proc.fast_cnt : i_proc.slow_cnt;
    while (emergency_stop !== 1'b1 && n < lim + 40) begin
      @(negedge clock);
      n++;
    end
    chk(16'(n >= lim + 1 && n <= lim + 9), 16'h1);
    @(posedge clock);
    i_proc.read_bit(ST_ESTOP, b);
    chk(16'(b), 16'h1);
  endtask

  // Main sequence
  initial begin
    do_reset();
    test_channels();
    test_status();
    test_wd(1'b1);
    do_reset();
    test_wd(1'b0);
    do_reset();
    summarize();
  end
endmodule
